// ==== logic/adc_irq_and_result_format.sv ====
// Purpose: completion flag, interrupt request, wake from halt and result justification
// Assumes: conversion done arrives as a one-cycle pulse on the system clock;
//          the halt request and sequencing handshakes come from core logic on the same clock
// Notes:   control writes that leave the rc clock selected are delayed through a
//          two-stage pipeline so the converter sees them late, as the rc domain would
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// (R1) done flag sets at every conversion end; here a done pulse while halted without the rc clock is ignored
// (R2) software clears flag; hardware never clears it
// (R3) request only when flag and enable set
// (R4) converting in halt only with rc clock
// (R5) enabled completion interrupt wakes halted device
// (R6) after wake, next instruction always executes
// (R7) vector only if both enables set
// (R8) 12-bit result left or right justified
// (R9) software result writes stored right justified
// (R10) fmt bit0 clear: written data reads shifted left four
// (R11) control logic follows selected conversion clock
// (R12) hardware set beats software clear
module adc_irq_and_result_format (
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire adc_irq_pkg::reg_req_t    regReq,
    output logic [7:0]                    readData,
    input  wire logic                     convDone,
    input  wire logic [11:0]              convResult,
    input  wire logic [15:0]              convError,
    input  wire logic                     chargePumpReadyIn,
    input  wire logic                     haltRequest,
    input  wire logic                     nextInstrDone,
    output logic                          convClockRun,
    output logic                          irqRequest,
    output logic                          coreHalted,
    output logic                          execNextInstr,
    output logic                          vectorToIsr
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [15:0] justify(input logic [11:0] value, input logic leftJust);
        justify = leftJust ? {value, 4'h0} : {4'h0, value};
    endfunction

    function automatic logic isWrite(input adc_irq_pkg::reg_req_t req, input logic [3:0] off);
        isWrite = req.write && (req.addr == off);
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  control0_reg,   control0_next;
    logic [7:0]  ctlDly1_reg,    ctlDly1_next;
    logic [7:0]  ctlDly2_reg,    ctlDly2_next;
    logic        doneFlag_reg,   doneFlag_next;
    logic        irqEnable_reg,  irqEnable_next;
    logic        globalEn_reg,   globalEn_next;
    logic [15:0] result_reg,     result_next;
    logic [15:0] lowerTh_reg,    lowerTh_next;
    logic [15:0] upperTh_reg,    upperTh_next;
    logic [7:0]  trigger_reg,    trigger_next;
    logic        charge_pump_on_reg,       charge_pump_on_next;
    logic        cpSync1_reg,    cpSync2_reg;
    logic [7:0]  readData_next;
    logic        effFmt0;
    logic        effRc;
    logic        doneSet;

    // control bits as the converter sees them: immediate on system clock, late on rc
    assign effFmt0 = control0_reg[adc_irq_pkg::BIT_CLKSEL] ?
                     ctlDly2_reg[adc_irq_pkg::BIT_FMT0] : control0_reg[adc_irq_pkg::BIT_FMT0]; // R11
    assign effRc   = control0_reg[adc_irq_pkg::BIT_CLKSEL] ?
                     ctlDly2_reg[adc_irq_pkg::BIT_CLKSEL] : 1'b0; // R11

    // a halted core stops the system-clock path, so a done pulse only counts on rc there
    assign doneSet = convDone && (!coreHalted || effRc); // R1 R4

    always_comb begin
        control0_next  = control0_reg;
        ctlDly1_next   = control0_reg;
        ctlDly2_next   = ctlDly1_reg;
        doneFlag_next  = doneFlag_reg;
        irqEnable_next = irqEnable_reg;
        globalEn_next  = globalEn_reg;
        result_next    = result_reg;
        lowerTh_next   = lowerTh_reg;
        upperTh_next   = upperTh_reg;
        trigger_next   = trigger_reg;
        charge_pump_on_next      = charge_pump_on_reg;
        if (isWrite(regReq, adc_irq_pkg::OFF_CONTROL0)) begin
            control0_next = regReq.wdata & adc_irq_pkg::CONTROL0_MASK;
        end
        if (isWrite(regReq, adc_irq_pkg::OFF_FLAG) && !regReq.wdata[adc_irq_pkg::BIT_DONE]) begin
            doneFlag_next = 1'b0; // R2
        end
        if (doneSet) begin
            doneFlag_next = 1'b1; // R1 R12
        end
        if (isWrite(regReq, adc_irq_pkg::OFF_ENABLE)) begin
            irqEnable_next = regReq.wdata[adc_irq_pkg::BIT_IRQ_EN];
        end
        if (isWrite(regReq, adc_irq_pkg::OFF_INTCTL0)) begin
            globalEn_next = regReq.wdata[adc_irq_pkg::BIT_GIE];
        end
        // software writes land right justified whatever the format
        if (isWrite(regReq, adc_irq_pkg::OFF_RESULT_LOW)) begin
            result_next[7:0] = regReq.wdata; // R9
        end
        if (isWrite(regReq, adc_irq_pkg::OFF_RESULT_HIGH)) begin
            result_next[15:8] = regReq.wdata; // R9
        end
        if (doneSet) begin
            result_next = {4'h0, convResult}; // R8
        end
        if (isWrite(regReq, adc_irq_pkg::OFF_LTH_LOW))  lowerTh_next[7:0]  = regReq.wdata;
        if (isWrite(regReq, adc_irq_pkg::OFF_LTH_HIGH)) lowerTh_next[15:8] = regReq.wdata;
        if (isWrite(regReq, adc_irq_pkg::OFF_UTH_LOW))  upperTh_next[7:0]  = regReq.wdata;
        if (isWrite(regReq, adc_irq_pkg::OFF_UTH_HIGH)) upperTh_next[15:8] = regReq.wdata;
        if (isWrite(regReq, adc_irq_pkg::OFF_TRIGGER)) begin
            trigger_next = regReq.wdata & adc_irq_pkg::TRIGGER_MASK;
        end
        if (isWrite(regReq, adc_irq_pkg::OFF_CHARGE_PUMP)) begin
            charge_pump_on_next = regReq.wdata[adc_irq_pkg::BIT_CHARGE_PUMP_ON];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control0_reg  <= adc_irq_pkg::RESET_BYTE;
            ctlDly1_reg   <= adc_irq_pkg::RESET_BYTE;
            ctlDly2_reg   <= adc_irq_pkg::RESET_BYTE;
            doneFlag_reg  <= 1'b0;
            irqEnable_reg <= 1'b0;
            globalEn_reg  <= 1'b0;
            result_reg    <= adc_irq_pkg::RESET_WORD;
            lowerTh_reg   <= adc_irq_pkg::RESET_WORD;
            upperTh_reg   <= adc_irq_pkg::RESET_WORD;
            trigger_reg   <= adc_irq_pkg::RESET_BYTE;
            charge_pump_on_reg      <= 1'b0;
            cpSync1_reg   <= 1'b0;
            cpSync2_reg   <= 1'b0;
        end else begin
            control0_reg  <= control0_next;
            ctlDly1_reg   <= ctlDly1_next;
            ctlDly2_reg   <= ctlDly2_next;
            doneFlag_reg  <= doneFlag_next;
            irqEnable_reg <= irqEnable_next;
            globalEn_reg  <= globalEn_next;
            result_reg    <= result_next;
            lowerTh_reg   <= lowerTh_next;
            upperTh_reg   <= upperTh_next;
            trigger_reg   <= trigger_next;
            charge_pump_on_reg      <= charge_pump_on_next;
            cpSync1_reg   <= chargePumpReadyIn;
            cpSync2_reg   <= cpSync1_reg;
        end
    end

    assign irqRequest   = doneFlag_reg && irqEnable_reg; // R3
    assign convClockRun = !coreHalted || effRc; // R4

    // ------------------------------------------------------------
    // halt and wake sequencing
    // ------------------------------------------------------------
    adc_irq_pkg::core_state_t coreState_reg, coreState_next;
    logic                     vector_reg,    vector_next;

    always_comb begin
        coreState_next = coreState_reg;
        vector_next    = 1'b0;
        case (coreState_reg)
            adc_irq_pkg::CORE_RUN: begin
                if (haltRequest) begin
                    coreState_next = adc_irq_pkg::CORE_HALT;
                end
            end
            adc_irq_pkg::CORE_HALT: begin
                if (irqRequest) begin
                    coreState_next = adc_irq_pkg::CORE_RESUME; // R5
                end
            end
            adc_irq_pkg::CORE_RESUME: begin
                // the following instruction runs first; vectoring waits for it
                if (nextInstrDone) begin
                    coreState_next = adc_irq_pkg::CORE_RUN; // R6
                    vector_next    = irqRequest && globalEn_reg; // R7
                end
            end
            default: begin
                coreState_next = adc_irq_pkg::CORE_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            coreState_reg <= adc_irq_pkg::CORE_RUN;
            vector_reg    <= 1'b0;
        end else begin
            coreState_reg <= coreState_next;
            vector_reg    <= vector_next;
        end
    end

    assign coreHalted    = (coreState_reg == adc_irq_pkg::CORE_HALT);
    assign execNextInstr = (coreState_reg == adc_irq_pkg::CORE_RESUME); // R6
    assign vectorToIsr   = vector_reg; // R7

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] resultView;
    // stored value is right justified; left format moves it up four places
    assign resultView = justify(result_reg[11:0], !effFmt0); // R8 R10

    always_comb begin
        readData_next = 8'h00;
        if (regReq.read) begin
            case (regReq.addr)
                adc_irq_pkg::OFF_CONTROL0:    readData_next = control0_reg;
                adc_irq_pkg::OFF_FLAG:        readData_next = {7'h00, doneFlag_reg};
                adc_irq_pkg::OFF_ENABLE:      readData_next = {7'h00, irqEnable_reg};
                adc_irq_pkg::OFF_INTCTL0:     readData_next = {globalEn_reg, 7'h00};
                adc_irq_pkg::OFF_RESULT_LOW:  readData_next = resultView[7:0];
                adc_irq_pkg::OFF_RESULT_HIGH: readData_next = resultView[15:8];
                adc_irq_pkg::OFF_ERROR_LOW:   readData_next = convError[7:0];
                adc_irq_pkg::OFF_ERROR_HIGH:  readData_next = convError[15:8];
                adc_irq_pkg::OFF_LTH_LOW:     readData_next = lowerTh_reg[7:0];
                adc_irq_pkg::OFF_LTH_HIGH:    readData_next = lowerTh_reg[15:8];
                adc_irq_pkg::OFF_UTH_LOW:     readData_next = upperTh_reg[7:0];
                adc_irq_pkg::OFF_UTH_HIGH:    readData_next = upperTh_reg[15:8];
                adc_irq_pkg::OFF_TRIGGER:     readData_next = trigger_reg;
                adc_irq_pkg::OFF_CHARGE_PUMP: readData_next = {charge_pump_on_reg, 6'h00, cpSync2_reg};
                default:                      readData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readData <= 8'h00;
        end else begin
            readData <= readData_next;
        end
    end

endmodule

`default_nettype wire

// ==== logic/adc_irq_pkg.sv ====
// Purpose: shared constants and carriers for the converter event and result block
// Assumes: 8-bit register port, 100 MHz system clock
// Notes:   register offsets have no documented address; the map below is local
package adc_irq_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CONTROL0     = 4'h0;
    localparam logic [3:0] OFF_FLAG         = 4'h1;
    localparam logic [3:0] OFF_ENABLE       = 4'h2;
    localparam logic [3:0] OFF_INTCTL0      = 4'h3;
    localparam logic [3:0] OFF_RESULT_LOW   = 4'h4;
    localparam logic [3:0] OFF_RESULT_HIGH  = 4'h5;
    localparam logic [3:0] OFF_ERROR_LOW    = 4'h6;
    localparam logic [3:0] OFF_ERROR_HIGH   = 4'h7;
    localparam logic [3:0] OFF_LTH_LOW      = 4'h8;
    localparam logic [3:0] OFF_LTH_HIGH     = 4'h9;
    localparam logic [3:0] OFF_UTH_LOW      = 4'ha;
    localparam logic [3:0] OFF_UTH_HIGH     = 4'hb;
    localparam logic [3:0] OFF_TRIGGER      = 4'hc;
    localparam logic [3:0] OFF_CHARGE_PUMP  = 4'hd;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_FMT0       = 2;   // control0: format_select_bit0
    localparam int BIT_CLKSEL     = 4;   // control0: 1 selects dedicated_rc_clock
    localparam int BIT_DONE       = 0;   // flag register: conversion_done_flag
    localparam int BIT_IRQ_EN     = 0;   // enable register: conversion_irq_enable
    localparam int BIT_GIE        = 7;   // interrupt_control_reg0: global_irq_enable
    localparam int BIT_CHARGE_PUMP_ON       = 7;   // charge_pump_on
    localparam int BIT_CHARGE_PUMP_READY      = 0;   // charge_pump_ready
    localparam logic [7:0] TRIGGER_MASK   = 8'h1f;
    localparam logic [7:0] CONTROL0_MASK  = 8'h14;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam int          RESULT_BITS  = 12;
    localparam int          JUSTIFY_SHIFT = 16 - RESULT_BITS;
    localparam int          RC_SYNC_STAGES = 2;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } reg_req_t;

    typedef enum logic [1:0] {
        CORE_RUN    = 2'b00,
        CORE_HALT   = 2'b01,
        CORE_RESUME = 2'b10
    } core_state_t;

endpackage

// ==== testbench/adc_irq_asserts.sv ====
// Purpose: port checks of flag, request, wake and read timing
// Assumes: enables tracked from the register writes seen at the port
// Notes:   rc settle taken as three cycles, covering the two-stage delay
`timescale 1ns/10ps
`default_nettype none
module adc_irq_asserts (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire adc_irq_pkg::reg_req_t regReq,
    input wire logic [7:0]            readData,
    input wire logic                  convDone,
    input wire logic                  haltRequest,
    input wire logic                  nextInstrDone,
    input wire logic                  convClockRun,
    input wire logic                  irqRequest,
    input wire logic                  coreHalted,
    input wire logic                  execNextInstr,
    input wire logic                  vectorToIsr
);
    // ------------------------------------------------------------
    // tracked enables
    // ------------------------------------------------------------
    logic enW, clrW, gieW, ctlW, irqEn_reg, irqEn_next, gie_reg, gie_next, rc_reg, rc_next;
    assign enW  = regReq.write && regReq.addr == adc_irq_pkg::OFF_ENABLE;
    assign clrW = regReq.write && regReq.addr == adc_irq_pkg::OFF_FLAG && !regReq.wdata[adc_irq_pkg::BIT_DONE];
    assign gieW = regReq.write && regReq.addr == adc_irq_pkg::OFF_INTCTL0;
    assign ctlW = regReq.write && regReq.addr == adc_irq_pkg::OFF_CONTROL0;
    always_comb begin
        irqEn_next = enW ? regReq.wdata[adc_irq_pkg::BIT_IRQ_EN] : irqEn_reg;
        gie_next   = gieW ? regReq.wdata[adc_irq_pkg::BIT_GIE] : gie_reg;
        rc_next    = ctlW ? regReq.wdata[adc_irq_pkg::BIT_CLKSEL] : rc_reg;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqEn_reg <= 1'b0;
            gie_reg   <= 1'b0;
            rc_reg    <= 1'b0;
        end else begin
            irqEn_reg <= irqEn_next;
            gie_reg   <= gie_next;
            rc_reg    <= rc_next;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_done_sets_irq: assert property (convDone && convClockRun && irqEn_reg && !enW |=> irqRequest)
        else $error("completion did not raise request");
    a_irq_cause: assert property ($rose(irqRequest) |-> $past(convDone && convClockRun) || $past(enW))
        else $error("request rose without cause");
    a_irq_needs_en: assert property (irqRequest |-> irqEn_reg)
        else $error("request while disabled");
    a_flag_stays: assert property (irqRequest && !clrW && !enW |=> irqRequest)
        else $error("flag dropped without clear");
    a_halt_no_clock: assert property (coreHalted && !(rc_reg || $past(rc_reg) || $past(rc_reg, 2)
        || $past(rc_reg, 3)) |-> !convClockRun)
        else $error("converter runs in halt without rc");
    a_wake_on_irq: assert property (coreHalted && irqRequest |=> execNextInstr)
        else $error("no wake on request");
    a_resume_holds: assert property (execNextInstr && !nextInstrDone |=> execNextInstr && !vectorToIsr)
        else $error("resume left early");
    a_vector_cause: assert property (vectorToIsr |-> $past(execNextInstr && nextInstrDone && irqRequest && gie_reg))
        else $error("vector without both enables");
    a_vector_taken: assert property (execNextInstr && nextInstrDone && irqRequest && gie_reg |=> vectorToIsr)
        else $error("vector missing");
    a_read_stands: assert property (!$past(regReq.read) |-> readData == 8'h00)
        else $error("read data outside its cycle");
    c_vector: cover property (vectorToIsr);
    c_halt_conv: cover property (coreHalted && convDone && convClockRun);
    c_set_clear: cover property (convDone && clrW);
endmodule
bind adc_irq_and_result_format adc_irq_asserts adc_irq_asserts_inst (.clock(clock), .rst_n(rst_n),
    .regReq(regReq), .readData(readData), .convDone(convDone), .haltRequest(haltRequest),
    .nextInstrDone(nextInstrDone), .convClockRun(convClockRun), .irqRequest(irqRequest),
    .coreHalted(coreHalted), .execNextInstr(execNextInstr), .vectorToIsr(vectorToIsr));
`default_nettype wire

// ==== testbench/core_model.sv ====
// Purpose: core stand-in that runs the instruction after wake
// Assumes: resume state shown on execNextInstr
// Notes:   slow mode stretches that instruction so a held resume is seen
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic execNextInstr,
    input  wire logic slowMode,
    output logic      nextInstrDone
);
    logic [2:0] cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt           <= 3'h0;
            nextInstrDone <= 1'b0;
        end else begin
            nextInstrDone <= execNextInstr && !nextInstrDone && cnt == (slowMode ? 3'h5 : 3'h1);
            cnt           <= (execNextInstr && !nextInstrDone) ? cnt + 3'h1 : 3'h0;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the converter event and result block
// Assumes: bench plays software and converter, core model answers resume
// Notes:   read data checked against an expectation queue
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                  clock = 0, rst_n = 0, convDone = 0, chargePumpReadyIn = 0, haltRequest = 0;
    logic                  slowMode = 0, rdPend = 0, nextInstrDone, convClockRun, irqRequest;
    logic                  coreHalted, execNextInstr, vectorToIsr;
    logic [7:0]            readData, d;
    logic [11:0]           convResult = '0, r;
    logic [15:0]           convError = '0;
    adc_irq_pkg::reg_req_t regReq = '0;
    logic [7:0]            expQ[$];
    int                    n_mismatch = 0, samples_checked = 0, cyc = 0, vecs = 0, i;
    int                    seed = 32'h7e1943d6;
    adc_irq_and_result_format adc_irq_and_result_format_inst (.clock(clock), .rst_n(rst_n), .regReq(regReq),
        .readData(readData), .convDone(convDone), .convResult(convResult), .convError(convError),
        .chargePumpReadyIn(chargePumpReadyIn), .haltRequest(haltRequest), .nextInstrDone(nextInstrDone),
        .convClockRun(convClockRun), .irqRequest(irqRequest), .coreHalted(coreHalted),
        .execNextInstr(execNextInstr), .vectorToIsr(vectorToIsr));
    core_model core_model_inst (.clock(clock), .rst_n(rst_n), .execNextInstr(execNextInstr),
        .slowMode(slowMode), .nextInstrDone(nextInstrDone));
    initial begin
        forever #5 clock = ~clock;
    end
    // ------------------------------------------------------------
    // drivers and comparisons
    // ------------------------------------------------------------
    task automatic cmp8(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(logic got, logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t flag %b want %b", $time, got, exp);
        end
    endtask
    // a read carries its expected byte on wdata, which the block ignores
    task automatic bus(logic w, logic [3:0] a, logic [7:0] v);
        @(posedge clock);
        regReq <= '{a, v, w, !w};
        if (!w) expQ.push_back(v);
    endtask
    task automatic nop(int n);
        @(posedge clock);
        regReq <= '0;
        repeat (n) @(posedge clock);
    endtask
    task automatic conv(logic [11:0] v);
        @(posedge clock);
        convDone   <= 1'b1;
        convResult <= v;
        @(posedge clock);
        convDone <= 1'b0;
    endtask
    task automatic halt();
        @(posedge clock);
        haltRequest <= 1'b1;
        @(posedge clock);
        haltRequest <= 1'b0;
        @(negedge clock);
        cmp1(coreHalted, 1'b1);
    endtask
    task automatic wake(logic s, logic g);
        slowMode <= s;
        i = vecs;
        conv(r);
        @(negedge clock);
        cmp1(irqRequest, 1'b1);
        @(negedge clock);
        cmp1(execNextInstr, 1'b1);
        for (int k = 0; k < 12 && execNextInstr === 1'b1; k++) @(negedge clock);
        repeat (2) @(negedge clock);
        cmp1(execNextInstr, 1'b0);
        cmp1(logic'(vecs - i == 1), g);
        bus(1, 4'h1, 8'h00);
        nop(1);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        if (rdPend) cmp8(readData, expQ.pop_front());
        rdPend <= regReq.read;
        if (vectorToIsr === 1'b1) vecs++;
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        convError = 16'($random(seed));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) bus(0, 4'(a), a == 6 ? convError[7:0] : a == 7 ? convError[15:8] : 8'h00);
        chargePumpReadyIn <= 1'b1;
        for (int a = 6; a < 16; a++) begin
            d = 8'($random(seed));
            bus(1, 4'(a), d);
            bus(0, 4'(a), a == 6 ? convError[7:0] : a == 7 ? convError[15:8] : a == 12 ? d & 8'h1f
                : a == 13 ? {d[7], 7'h01} : a > 13 ? 8'h00 : d);
        end
        bus(1, 4'h0, 8'hff);
        bus(0, 4'h0, 8'h14);
        bus(1, 4'h0, 8'h00);
        nop(4);
        r = 12'($random(seed));
        conv(r);
        @(negedge clock);
        cmp1(irqRequest, 1'b0);
        bus(0, 4'h1, 8'h01);
        bus(1, 4'h1, 8'h01);
        bus(1, 4'h2, 8'h01);
        bus(0, 4'h1, 8'h01);
        bus(0, 4'h4, {r[3:0], 4'h0});
        bus(0, 4'h5, r[11:4]);
        bus(1, 4'h0, 8'h04);
        nop(3);
        cmp1(irqRequest, 1'b1);
        bus(0, 4'h4, r[7:0]);
        bus(0, 4'h5, {4'h0, r[11:8]});
        bus(1, 4'h1, 8'h00);
        nop(0);
        @(negedge clock);
        cmp1(irqRequest, 1'b0);
        r = 12'($random(seed));
        @(posedge clock);
        convDone <= 1'b1;
        regReq   <= '{4'h1, 8'h00, 1'b1, 1'b0};
        nop(0);
        convDone <= 1'b0;
        @(negedge clock);
        cmp1(irqRequest, 1'b1);
        r = 12'($random(seed));
        bus(1, 4'h4, r[7:0]);
        bus(1, 4'h5, {4'h0, r[11:8]});
        bus(0, 4'h4, r[7:0]);
        bus(0, 4'h5, {4'h0, r[11:8]});
        bus(1, 4'h0, 8'h00);
        bus(1, 4'h1, 8'h00);
        nop(3);
        bus(0, 4'h4, {r[3:0], 4'h0});
        bus(0, 4'h5, r[11:4]);
        nop(1);
        halt();
        cmp1(convClockRun, 1'b0);
        conv(r);
        nop(2);
        @(negedge clock);
        cmp1(irqRequest, 1'b0);
        cmp1(coreHalted, 1'b1);
        bus(1, 4'h0, 8'h10);
        nop(4);
        @(negedge clock);
        cmp1(convClockRun, 1'b1);
        wake(1'b1, 1'b0);
        bus(1, 4'h3, 8'h80);
        nop(1);
        halt();
        wake(1'b0, 1'b1);
        nop(2);
        print_verdict();
    end
endmodule
`default_nettype wire
